// ==== core/audio_monitor_pkg.sv ====
// Purpose: constants for the digital audio monitor and clock select block
// Assumes: pclk at 40 MHz; apb with 32-bit data, word aligned registers
// Notes: register offsets are byte addresses
//
// Behaviour
// - take audio from one of three inputs
// - channel status and copy bits ignored
// - all outputs carry the same signal
// - error flag while active input invalid
// - report unrecognized rate and unlocked input
// - refresh frequency and format every half second
// - flag two-channel format on valid serial audio
// - record monitor mode passes input while recording
// - playback exclusive mode never routes input
// - idle monitor mode routes input when not playing
// - input selection change applies at once
// - host configuration writes apply immediately
// - follow mode switches to recovered clock on match
// - follow also locks at double or half rate
// - internal mode uses crystal, ignores inputs
// - track input rates from 25 to 102 kHz
// - follow incoming rate changes without delay
// - word clock mode accepts 25 to 102 kHz
// - record and playback paths run independently
package audio_monitor_pkg;
   localparam logic [11:0] ctrl_addr   = 12'h000;
   localparam logic [11:0] status_addr = 12'h004;
   localparam logic [11:0] rate_addr   = 12'h008;
   localparam logic [11:0] play_addr   = 12'h00C;

   localparam int input_sel_lsb   = 0;
   localparam int monitor_lsb     = 2;
   localparam int clock_mode_lsb  = 4;
   localparam int record_bit      = 6;
   localparam int playback_bit    = 7;
   localparam logic [31:0] ctrl_reset = 32'h0000_0000;

   localparam int error_bit       = 0;
   localparam int unrecog_bit     = 1;
   localparam int unlocked_bit    = 2;
   localparam int two_ch_bit      = 3;
   localparam int recovered_bit   = 4;
   localparam int internal_bit    = 5;

   localparam int clk_hz          = 40_000_000;
   localparam int refresh_ms      = 500;
   localparam int refresh_cycles  = clk_hz / 1000 * refresh_ms;
   localparam int min_rate_hz     = 25_000;
   localparam int max_rate_hz     = 102_000;
   // word period in pclk cycles; longest bound from lowest rate
   localparam int max_period      = clk_hz / min_rate_hz;
   localparam int min_period      = (clk_hz + max_rate_hz - 1) / max_rate_hz;
   localparam int rate_tol        = 4;
   localparam int loss_cycles     = 2 * max_period;

   typedef enum logic [2:0] {
      mon_record  = 3'b001,
      mon_play_ex = 3'b010,
      mon_idle    = 3'b100
   } monitor_mode_t;

   typedef enum logic [2:0] {
      clk_internal = 3'b001,
      clk_follow   = 3'b010,
      clk_wordclk  = 3'b100
   } clock_mode_t;
endpackage : audio_monitor_pkg

// ==== core/audio_monitor.sv ====
// Purpose: input select, lock and rate detection, monitor routing, clock select
// Assumes: frame syncs and data from pins are asynchronous to pclk
// Notes: one 2-bit code per select field in ctrl, single bits for record and playback; codes 3 of selects map to defaults
`timescale 1ns/1ps
module audio_monitor (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  in_frame,
   input  wire logic [2:0]  in_data,
   input  wire logic [2:0]  in_valid,
   input  wire logic        word_clock,
   input  wire logic        play_data,
   output logic             out_data,
   output logic             error_led,
   output logic             use_recovered,
   output logic             use_wordclk
);
   logic [31:0] ctrl;
   logic [31:0] play_rate;
   logic [2:0]  fs1, fs2, fs3, ds1, ds2, vs1, vs2;
   logic        wc1, wc2, wc3;
   logic [15:0] per_cnt, period;
   logic [15:0] wper_cnt, wperiod;
   logic [25:0] refresh_cnt;
   logic [15:0] shown_period;
   logic        shown_two_ch, shown_unrec, shown_unlock;
   logic        locked;

   wire [1:0] sel      = ctrl[audio_monitor_pkg::input_sel_lsb +: 2];
   wire [1:0] mon_code = ctrl[audio_monitor_pkg::monitor_lsb +: 2];
   wire [1:0] clk_code = ctrl[audio_monitor_pkg::clock_mode_lsb +: 2];
   wire       recording = ctrl[audio_monitor_pkg::record_bit];
   wire       playing   = ctrl[audio_monitor_pkg::playback_bit];

   // one active input; only edge timing and validity matter, status bits unseen
   wire [1:0] idx       = (sel > 2'd2) ? 2'd0 : sel;
   wire       fr_now    = fs2[idx];
   wire       fr_prev   = fs3[idx];
   wire       fr_edge   = fr_now & ~fr_prev;
   wire       act_data  = ds2[idx];
   wire       act_valid = vs2[idx];
   wire       wc_edge   = wc2 & ~wc3;

   wire in_range   = (period >= 16'(audio_monitor_pkg::min_period))
                   && (period <= 16'(audio_monitor_pkg::max_period));
   wire wc_range   = (wperiod >= 16'(audio_monitor_pkg::min_period))
                   && (wperiod <= 16'(audio_monitor_pkg::max_period));
   wire lost       = per_cnt >= 16'(audio_monitor_pkg::loss_cycles);
   wire input_good = act_valid && !lost && in_range;
   wire [15:0] pp  = play_rate[15:0];
   function automatic logic near(input logic [15:0] a, input logic [15:0] b);
      logic [15:0] d;
      d = (a > b) ? a - b : b - a;
      return d <= 16'(audio_monitor_pkg::rate_tol);
   endfunction : near
   // match at equal, double or half rate; the pll covers only these ratios
   wire match_equal  = near(period, pp);
   wire match_double = near(period, {pp[14:0], 1'b0});
   wire match_half   = near(period, {1'b0, pp[15:1]});
   wire rate_match   = match_equal || match_double || match_half;

   // routing decision, outputs paralleled from one source
   wire pass_input = (mon_code == 2'd0) ? recording :
                     (mon_code == 2'd1) ? 1'b0 :
                     (mon_code == 2'd2) ? !playing :
                     recording;
   wire next_out   = pass_input ? act_data : play_data;

   // follow mode: take recovered clock only with a matching locked input
   wire follow        = (clk_code == 2'd1);
   wire next_recov    = follow && input_good && (locked ? 1'b1 : rate_match);
   wire next_wordclk  = (clk_code == 2'd2) && wc_range;

   wire rd_en = psel && !penable && !pwrite;
   wire wr_en = psel && penable && pwrite;
   wire hit_ctrl = paddr == audio_monitor_pkg::ctrl_addr;
   wire hit_stat = paddr == audio_monitor_pkg::status_addr;
   wire hit_rate = paddr == audio_monitor_pkg::rate_addr;
   wire hit_play = paddr == audio_monitor_pkg::play_addr;
   wire mapped   = hit_ctrl || hit_stat || hit_rate || hit_play;
   wire [31:0] status_word = {26'h000_0000, !use_recovered && !use_wordclk, use_recovered,
                              shown_two_ch, shown_unlock, shown_unrec, !input_good};
   wire [31:0] rd_word = hit_ctrl ? ctrl :
                         hit_stat ? status_word :
                         hit_rate ? {16'h0000, shown_period} :
                         hit_play ? play_rate : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs1 <= 3'h0; fs2 <= 3'h0; fs3 <= 3'h0;
         ds1 <= 3'h0; ds2 <= 3'h0; vs1 <= 3'h0; vs2 <= 3'h0;
         wc1 <= 1'b0; wc2 <= 1'b0; wc3 <= 1'b0;
      end else begin
         fs1 <= in_frame; fs2 <= fs1; fs3 <= fs2;
         ds1 <= in_data;  ds2 <= ds1;
         vs1 <= in_valid; vs2 <= vs1;
         wc1 <= word_clock; wc2 <= wc1; wc3 <= wc2;
      end
   end

   // period meter follows the selected input; a switch costs one odd period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_cnt <= 16'h0000;
         period  <= 16'h0000;
      end else if (fr_edge) begin
         per_cnt <= 16'h0001;
         period  <= per_cnt;
      end else if (!lost) begin
         per_cnt <= per_cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wper_cnt <= 16'h0000;
         wperiod  <= 16'h0000;
      end else if (wc_edge) begin
         wper_cnt <= 16'h0001;
         wperiod  <= wper_cnt;
      end else if (wper_cnt < 16'(audio_monitor_pkg::loss_cycles)) begin
         wper_cnt <= wper_cnt + 16'h0001;
      end else begin
         wperiod  <= 16'h0000;
      end
   end

   // shown figures only move at the half-second tick
   wire refresh_tick = refresh_cnt == 26'(audio_monitor_pkg::refresh_cycles - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refresh_cnt  <= 26'h000_0000;
         shown_period <= 16'h0000;
         shown_two_ch <= 1'b0;
         shown_unrec  <= 1'b1;
         shown_unlock <= 1'b1;
      end else if (refresh_tick) begin
         refresh_cnt  <= 26'h000_0000;
         shown_period <= period;
         shown_unrec  <= !in_range;
         shown_unlock <= !act_valid || lost;
         shown_two_ch <= input_good;
      end else begin
         refresh_cnt  <= refresh_cnt + 26'h000_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_data      <= 1'b0;
         error_led     <= 1'b1;
         use_recovered <= 1'b0;
         use_wordclk   <= 1'b0;
         locked        <= 1'b0;
      end else begin
         out_data      <= next_out;
         error_led     <= !input_good;
         use_recovered <= next_recov;
         use_wordclk   <= next_wordclk;
         locked        <= next_recov;
      end
   end

   // writes land at the access edge and act on the next cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl      <= audio_monitor_pkg::ctrl_reset;
         play_rate <= 32'h0000_0000;
      end else if (wr_en && hit_ctrl) begin
         ctrl      <= pwdata;
      end else if (wr_en && hit_play) begin
         play_rate <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (rd_en) begin
            prdata <= rd_word;
         end
      end
   end

   property p_pass_exclusive;
      @(posedge pclk) disable iff (!presetn)
         (mon_code == 2'd1) |=> (out_data == $past(play_data));
   endproperty
   a_pass_exclusive: assert property (p_pass_exclusive) else $error("input routed in exclusive mode");

   property p_led;
      @(posedge pclk) disable iff (!presetn)
         input_good |=> !error_led;
   endproperty
   a_led: assert property (p_led) else $error("error led stuck");

   property p_internal;
      @(posedge pclk) disable iff (!presetn)
         (clk_code == 2'd0) |=> !use_recovered && !use_wordclk;
   endproperty
   a_internal: assert property (p_internal) else $error("input timing used in internal mode");

   property p_drop;
      @(posedge pclk) disable iff (!presetn)
         (use_recovered && !input_good) |=> !use_recovered;
   endproperty
   a_drop: assert property (p_drop) else $error("recovered clock kept after loss");

   property p_idle;
      @(posedge pclk) disable iff (!presetn)
         (mon_code == 2'd2 && !playing) |=> (out_data == $past(act_data));
   endproperty
   a_idle: assert property (p_idle) else $error("idle monitor not routing input");

   property p_record;
      @(posedge pclk) disable iff (!presetn)
         (mon_code == 2'd0 && !recording) |=> (out_data == $past(play_data));
   endproperty
   a_record: assert property (p_record) else $error("input routed while not recording");

   property p_write;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && hit_ctrl) |=> (ctrl == $past(pwdata));
   endproperty
   a_write: assert property (p_write) else $error("control write not applied");

   property p_refresh;
      @(posedge pclk) disable iff (!presetn)
         !refresh_tick |=> (shown_period == $past(shown_period));
   endproperty
   a_refresh: assert property (p_refresh) else $error("shown rate moved between ticks");

   // steps reused by the properties below
   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_match;
      follow && input_good && rate_match;
   endsequence

   sequence s_tick;
      refresh_tick;
   endsequence

   sequence s_switch;
      $changed(idx) && pass_input;
   endsequence

   property p_answer;
      @(posedge pclk) disable iff (!presetn)
         s_setup |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no ready after setup");

   property p_ready_pulse;
      @(posedge pclk) disable iff (!presetn)
         (pready && penable) |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past access");

   property p_unmapped;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && !mapped) |=> (pslverr && pready);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

   property p_read_ctrl;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && !pwrite && hit_ctrl) |=> (prdata == $past(ctrl));
   endproperty
   a_read_ctrl: assert property (p_read_ctrl) else $error("control read data wrong");

   property p_play_write;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && hit_play) |=> (play_rate == $past(pwdata));
   endproperty
   a_play_write: assert property (p_play_write) else $error("playback period write not applied");

   property p_stray_write;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && !mapped) |=> (ctrl == $past(ctrl)) && (play_rate == $past(play_rate));
   endproperty
   a_stray_write: assert property (p_stray_write) else $error("unmapped write changed a register");

   property p_led_set;
      @(posedge pclk) disable iff (!presetn)
         !input_good |=> error_led;
   endproperty
   a_led_set: assert property (p_led_set) else $error("error led dark on bad input");

   property p_lost;
      @(posedge pclk) disable iff (!presetn)
         lost |-> !input_good;
   endproperty
   a_lost: assert property (p_lost) else $error("lost input counted as good");

   property p_record_pass;
      @(posedge pclk) disable iff (!presetn)
         (mon_code == 2'd0 && recording) |=> (out_data == $past(act_data));
   endproperty
   a_record_pass: assert property (p_record_pass) else $error("input not routed while recording");

   property p_idle_play;
      @(posedge pclk) disable iff (!presetn)
         (mon_code == 2'd2 && playing) |=> (out_data == $past(play_data));
   endproperty
   a_idle_play: assert property (p_idle_play) else $error("input routed during playback");

   property p_switch;
      @(posedge pclk) disable iff (!presetn)
         s_switch |=> (out_data == $past(act_data));
   endproperty
   a_switch: assert property (p_switch) else $error("new input not routed at once");

   property p_follow_take;
      @(posedge pclk) disable iff (!presetn)
         s_match |=> use_recovered;
   endproperty
   a_follow_take: assert property (p_follow_take) else $error("matching input not followed");

   property p_follow_wait;
      @(posedge pclk) disable iff (!presetn)
         (follow && !use_recovered && !rate_match) |=> !use_recovered;
   endproperty
   a_follow_wait: assert property (p_follow_wait) else $error("recovered clock taken without match");

   property p_ratio;
      @(posedge pclk) disable iff (!presetn)
         (follow && input_good && (match_double || match_half)) |=> use_recovered;
   endproperty
   a_ratio: assert property (p_ratio) else $error("double or half rate not followed");

   property p_follow_hold;
      @(posedge pclk) disable iff (!presetn)
         (follow && input_good && use_recovered) |=> use_recovered;
   endproperty
   a_follow_hold: assert property (p_follow_hold) else $error("recovered clock dropped on good input");

   property p_range_drop;
      @(posedge pclk) disable iff (!presetn)
         (use_recovered && !in_range) |=> !use_recovered;
   endproperty
   a_range_drop: assert property (p_range_drop) else $error("recovered clock kept rate_unrecognized_indication");

   property p_one_source;
      @(posedge pclk) disable iff (!presetn)
         !(use_recovered && use_wordclk);
   endproperty
   a_one_source: assert property (p_one_source) else $error("two clock sources selected");

   property p_wordclk_take;
      @(posedge pclk) disable iff (!presetn)
         (clk_code == 2'd2 && wc_range) |=> use_wordclk;
   endproperty
   a_wordclk_take: assert property (p_wordclk_take) else $error("word clock not taken");

   property p_wordclk_drop;
      @(posedge pclk) disable iff (!presetn)
         !wc_range |=> !use_wordclk;
   endproperty
   a_wordclk_drop: assert property (p_wordclk_drop) else $error("word clock used rate_unrecognized_indication");

   property p_status_tick;
      @(posedge pclk) disable iff (!presetn)
         s_tick |=> (shown_unrec == !$past(in_range)) && (shown_unlock == (!$past(act_valid) || $past(lost)));
   endproperty
   a_status_tick: assert property (p_status_tick) else $error("status flags not refreshed at tick");

   property p_two_ch;
      @(posedge pclk) disable iff (!presetn)
         s_tick |=> (shown_two_ch == $past(input_good));
   endproperty
   a_two_ch: assert property (p_two_ch) else $error("format flag not refreshed at tick");
endmodule : audio_monitor

// ==== bench/audio_source_model.sv ====
// Purpose: external audio sources and word clock facing the monitor block
// Assumes: 48 kHz frames, serial bit clock of 200 ns
// Notes: an invalid input has no frame edges and a toggling data line
`timescale 1ns/1ps
module audio_source_model (
   input  wire logic [2:0] valid,
   input  wire logic [2:0] level,
   input  wire logic       wc_on,
   output logic      [2:0] in_frame,
   output logic      [2:0] in_data,
   output logic      [2:0] in_valid,
   output logic            word_clock
);
   logic frame;
   logic bit_clk;
   initial begin
      frame = 1'b0;
      forever #10417 frame = ~frame;
   end
   initial begin
      bit_clk = 1'b0;
      forever #100 bit_clk = ~bit_clk;
   end
   // a dead input must not look like a steady level
   assign in_frame   = valid & {3{frame}};
   assign in_data    = (valid & level) | (~valid & {3{bit_clk}});
   assign in_valid   = valid;
   assign word_clock = wc_on & frame;
endmodule : audio_source_model

// ==== bench/test_audio_monitor.sv ====
// Purpose: register, routing and clock select checks of the audio monitor
// Assumes: apb answers after one access cycle
// Notes: status refresh at 0.5 s is too long for this run
`timescale 1ns/1ps
module test_audio_monitor;
   logic pclk, presetn, psel, penable, pwrite, play_data, wc_on;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, out_data, error_led, use_recovered, use_wordclk, e;
   logic [2:0] in_frame, in_data, in_valid, valid, level;
   int n_mismatch, samples_checked;
   wire logic [2:0] flags = {use_wordclk, use_recovered, error_led};
   wire logic       word_clock_w;
   audio_monitor audio_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_frame(in_frame), .in_data(in_data), .in_valid(in_valid), .word_clock(word_clock_w),
      .play_data(play_data), .out_data(out_data), .error_led(error_led), .use_recovered(use_recovered),
      .use_wordclk(use_wordclk));
   audio_source_model audio_source_model_inst (.valid(valid), .level(level), .wc_on(wc_on),
      .in_frame(in_frame), .in_data(in_data), .in_valid(in_valid), .word_clock(word_clock_w));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task conclude;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (k >= 50) begin
         n_mismatch++;
         conclude();
      end
   endtask : apb
   // one word: select, monitor, clock, record, playback
   task set_ctrl(input int s, input int m, input int c, input int r, input int p);
      apb(1'b1, audio_monitor_pkg::ctrl_addr, 32'(s) | 32'(m) << 2 | 32'(c) << 4 | 32'(r) << 6 | 32'(p) << 7);
   endtask : set_ctrl
   task wait_flag(input int i, input logic v, input int n);
      int k;
      k = 0;
      while (flags[i] !== v && k < n) begin
         @(posedge pclk);
         k++;
      end
      chk({31'h0, flags[i]}, {31'h0, v});
      if (flags[i] !== v) conclude();
   endtask : wait_flag
   logic exp;
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0000_0000; play_data = 1'b0; wc_on = 1'b0; valid = 3'b111; level = 3'b101;
      repeat (2) @(posedge pclk);
      chk({31'h0, error_led}, 32'h0000_0001);
      chk({30'h0, use_wordclk, use_recovered}, 32'h0000_0000);
      presetn <= 1'b1;
      $display("test reset done");
      set_ctrl(2, 1, 0, 1, 1);
      apb(1'b0, audio_monitor_pkg::ctrl_addr, 32'h0000_0000);
      chk(q, 32'h0000_00C6);
      apb(1'b1, audio_monitor_pkg::play_addr, 32'h0000_0341);
      apb(1'b0, audio_monitor_pkg::play_addr, 32'h0000_0000);
      chk(q, 32'h0000_0341);
      apb(1'b0, audio_monitor_pkg::status_addr, 32'h0000_0000);
      chk(q & 32'h0000_0030, 32'h0000_0020);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk({q[30:0], e}, 32'h0000_0001);
      $display("test registers done");
      for (int s = 0; s < 3; s++)
         for (int m = 0; m < 4; m++)
            for (int c = 0; c < 4; c++) begin
               play_data <= ~level[s];
               set_ctrl(s, m, 0, c % 2, c / 2);
               repeat (4) @(posedge pclk);
               exp = (m == 1) ? ~level[s] : (m == 2) ? (c / 2 ? ~level[s] : level[s])
                   : (c % 2 ? level[s] : ~level[s]);
               chk({31'h0, out_data}, {31'h0, exp});
            end
      play_data <= 1'b0;
      set_ctrl(3, 2, 0, 0, 0);
      repeat (4) @(posedge pclk);
      chk({31'h0, out_data}, {31'h0, level[0]});
      $display("test routing done");
      set_ctrl(1, 0, 0, 0, 0);
      valid <= 3'b101;
      wait_flag(0, 1'b1, 20);
      valid <= 3'b111;
      wait_flag(0, 1'b0, 3000);
      $display("test error done");
      apb(1'b1, audio_monitor_pkg::play_addr, 32'h0000_0682);
      set_ctrl(1, 0, 1, 0, 1);
      wait_flag(1, 1'b1, 3000);
      valid <= 3'b101;
      wait_flag(1, 1'b0, 3300);
      apb(1'b1, audio_monitor_pkg::play_addr, 32'h0000_0341);
      valid <= 3'b111;
      wait_flag(1, 1'b1, 4000);
      set_ctrl(1, 0, 0, 0, 1);
      wait_flag(1, 1'b0, 10);
      wc_on <= 1'b1;
      set_ctrl(1, 0, 2, 0, 1);
      wait_flag(2, 1'b1, 3000);
      set_ctrl(1, 0, 3, 0, 1);
      wait_flag(2, 1'b0, 10);
      $display("test clock select done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({29'h0, flags}, 32'h0000_0001);
      presetn <= 1'b1;
      apb(1'b0, audio_monitor_pkg::ctrl_addr, 32'h0000_0000);
      chk(q, audio_monitor_pkg::ctrl_reset);
      $display("test reset again done");
      conclude();
   end
endmodule : test_audio_monitor
